// File: sim/tv_encoder_pixel_input_port_tb_top.sv
// Self-checking bench for the pixel input port.
`timescale 1ns/1ns
module tv_encoder_pixel_input_port_tb_top;
    logic               clk, resetn, mon_en;
    tv_pix_pkg::link_s  link;
    tv_pix_pkg::cfg_s   cfg;
    tv_pix_pkg::pixel_s pixel, exp_q[$];
    logic               ref_clock_out, hsync_out, vsync_out, sync_out_en;
    logic               pixel_valid, line_start, field, vblank;
    logic               format_error, clock_limit_error;
    logic [31:0]        seed;
    int                 miscompares, n_compared, n_lines;

    tv_gfx_model gfx (.clk, .link);
    tv_pixel_input_port dut (.clk, .resetn, .capture_clock_in(link.clk),
        .hsync_in(link.hs), .vsync_in(link.vs), .pixel_word(link.d), .cfg,
        .ref_clock_out, .hsync_out, .vsync_out, .sync_out_en, .pixel,
        .pixel_valid, .line_start, .field, .vblank, .format_error,
        .clock_limit_error);

    always #50 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic tv_pix_pkg::pixel_s exp_rgb(input logic [3:0] f,
                                                  input logic [15:0] w);
        tv_pix_pkg::pixel_s p;
        p    = '0;
        p.c0 = (f == tv_pix_pkg::FMT_565) ? {w[15:11], 3'h0} : {w[14:10], 3'h0};
        p.c1 = (f == tv_pix_pkg::FMT_565) ? {w[10:5], 2'h0} : {w[9:5], 3'h0};
        p.c2 = {w[4:0], 3'h0};
        return p;
    endfunction : exp_rgb

    task automatic miss(input string m);
        miscompares++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : miss

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) miss($sformatf("flag %b want %b", got, exp));
    endtask : cmp_bit

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) miss($sformatf("count %0d want %0d", got, exp));
    endtask : cmp_val

    task automatic cmp_pix(input tv_pix_pkg::pixel_s got,
                           input tv_pix_pkg::pixel_s exp);
        n_compared++;
        if (got !== exp) miss($sformatf("pixel %h want %h", got, exp));
    endtask : cmp_pix

    // Pixels are checked in arrival order.
    always @(negedge clk) begin
        if (line_start === 1'b1) n_lines++;
        if (mon_en && pixel_valid === 1'b1) begin
            if (exp_q.size() == 0) cmp_bit(1'b1, 1'b0);
            else cmp_pix(pixel, exp_q.pop_front());
        end
    end

    // A polarity flip is no real word, so checks pause.
    task automatic setup(input logic [3:0] f, input logic inv,
                         input logic emb, input logic [11:0] off);
        mon_en       = 1'b0;
        cfg.fmt      = f;
        cfg.invert   = inv;
        cfg.embedded = emb;
        cfg.offset   = off;
        gfx.set_pol(inv);
        repeat (6) @(negedge clk);
        exp_q.delete();
        mon_en = 1'b1;
    endtask : setup

    task automatic finish_test(input string name);
        repeat (8) @(negedge clk);
        cmp_val(16'(exp_q.size()), 16'h0000);
        $display("test %s done", name);
    endtask : finish_test

    task automatic run_rgb(input logic [3:0] f, input logic inv,
                           input logic [11:0] off);
        logic [15:0] w;
        int          n;
        setup(f, inv, 1'b0, off);
        n = n_lines;
        gfx.hpulse(inv);
        cmp_val(16'(n_lines), 16'(n + 1));
        cmp_bit(vblank, inv);
        for (int i = 0; i < 6 + off; i++) begin
            w = (i == off) ? 16'hffff : (i == off + 1) ? 16'h0000 : 16'(rnd());
            if (i >= off) exp_q.push_back(exp_rgb(f, w));
            gfx.word(w);
        end
        finish_test("rgb");
    endtask : run_rgb

    task automatic trs(input logic [7:0] s);
        gfx.word(16'h00ff);
        gfx.word({s, 8'h00});
        repeat (2) @(negedge clk);
    endtask : trs

    task automatic run_ycc(input logic emb);
        logic [31:0] w;
        int          n;
        setup(tv_pix_pkg::FMT_YCC16, 1'b0, emb, 12'h000);
        gfx.hpulse(1'b0);
        w = rnd();
        if (emb) begin
            trs(w[7:0] | 8'h10);
            trs(w[15:8] & 8'hef);
            cmp_bit(field, w[14]);
            cmp_bit(vblank, w[13]);
        end
        for (int i = 0; i < 4; i++) begin
            w = rnd();
            exp_q.push_back({w[31:24], w[23:16], w[7:0], w[15:8], 1'b1});
            gfx.word(w[31:16]);
            gfx.word(w[15:0]);
        end
        n = n_lines;
        if (emb) trs(8'h10);
        cmp_val(16'(n_lines), 16'(n + int'(emb)));
        finish_test("ycc");
    endtask : run_ycc

    task automatic run_mux(input logic [11:0] off);
        logic [31:0] w;
        setup(tv_pix_pkg::FMT_888X3, 1'b0, 1'b0, off);
        gfx.hpulse(1'b0);
        for (int i = 0; i < 4; i++) begin
            w = rnd();
            if (i >= off) exp_q.push_back({w[23:0], 8'h00, 1'b0});
            gfx.edge_word({w[31:24], w[7:0]});
            gfx.edge_word({w[31:24], w[15:8]});
            gfx.edge_word({w[31:24], w[23:16]});
        end
        finish_test("mux");
    endtask : run_mux

    task automatic run_ref();
        int n;
        for (int m = 1; m <= 3; m++) begin
            cfg.master = 1'b1;
            cfg.mult   = 2'(m);
            for (n = 0; n < 40 && ref_clock_out !== 1'b0; n++) @(negedge clk);
            for (n = 0; n < 40 && ref_clock_out !== 1'b1; n++) @(negedge clk);
            for (n = 0; n < 40 && ref_clock_out === 1'b1; n++) @(negedge clk);
            cmp_val(16'(n), 16'(12 / m));
        end
        cfg.master   = 1'b0;
        cfg.sync_gen = 1'b1;
        repeat (3) @(negedge clk);
        cmp_bit(ref_clock_out, 1'b0);
        cmp_bit(sync_out_en, 1'b1);
        cfg.sync_gen = 1'b0;
        $display("test ref done");
    endtask : run_ref

    task automatic run_err();
        logic [5:0] tab [4] = '{6'h03, 6'h2d, 6'h26, 6'h06};
        for (int i = 0; i < 4; i++) begin
            setup(tab[i][5:2], 1'b0, tab[i][1], 12'h000);
            cmp_bit(format_error, tab[i][0]);
        end
        $display("test err done");
    endtask : run_err

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // The tests need well under a tenth of this span.
    initial begin
        #5_000_000;
        miss("watchdog expired");
        report_and_stop();
    end

    initial begin
        clk            = 1'b0;
        resetn         = 1'b0;
        mon_en         = 1'b0;
        cfg            = '0;
        cfg.mult       = 2'h1;
        cfg.line_total = 12'h028;
        seed           = 32'h54905ad2;
        repeat (3) @(negedge clk);
        cmp_bit(|{pixel_valid, ref_clock_out, format_error}, 1'b0);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        run_rgb(tv_pix_pkg::FMT_565, 1'b0, 12'h000);
        run_rgb(tv_pix_pkg::FMT_555, 1'b1, 12'h002);
        run_ycc(1'b0);
        run_ycc(1'b1);
        run_mux(12'h001);
        run_ref();
        run_err();
        report_and_stop();
    end
endmodule : tv_encoder_pixel_input_port_tb_top

// File: sim/tv_gfx_model.sv
// Graphics controller model that drives the capture link.
`timescale 1ns/1ns
module tv_gfx_model (
    // Clock
    input  wire logic         clk,
    // Link towards the port
    output tv_pix_pkg::link_s link
);
    logic pol;

    initial begin
        pol  = 1'b0;
        link = '0;
    end

    // The clock rests idle until the first word.
    task automatic set_pol(input logic p);
        pol      = p;
        link.clk <= p;
    endtask : set_pol

    // One capture edge per word, 800 ns period.
    task automatic word(input logic [15:0] d);
        link.d   <= d;
        link.clk <= pol;
        repeat (4) @(negedge clk);
        link.clk <= ~pol;
        repeat (4) @(negedge clk);
    endtask : word

    // Each edge carries a word at 1X multiplexed.
    task automatic edge_word(input logic [15:0] d);
        link.d <= d;
        repeat (3) @(negedge clk);
        link.clk <= ~link.clk;
        @(negedge clk);
    endtask : edge_word

    // Data is released to its inverse while sync is high.
    task automatic hpulse(input logic v);
        link.d  <= ~link.d;
        link.vs <= v;
        link.hs <= 1'b1;
        repeat (16) @(negedge clk);
        link.hs <= 1'b0;
        repeat (8) @(negedge clk);
    endtask : hpulse
endmodule : tv_gfx_model

// File: sim/tv_pix_checker.sv
// Port assertions for the pixel input port.
`timescale 1ns/1ns
module tv_pix_checker (
    // Clock and reset
    input wire logic               clk,
    input wire logic               resetn,
    // Observed ports
    input wire tv_pix_pkg::cfg_s   cfg,
    input wire logic               ref_clock_out,
    input wire logic               sync_out_en,
    input wire tv_pix_pkg::pixel_s pixel,
    input wire logic               pixel_valid,
    input wire logic               line_start,
    input wire logic               format_error,
    input wire logic               clock_limit_error
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_slave_quiet;
        !$past(cfg.master) |-> !ref_clock_out;
    endproperty
    property p_ref_half2;
        $rose(ref_clock_out) && cfg.master && cfg.mult == 2'h2
            |-> ref_clock_out [*6] ##1 !ref_clock_out;
    endproperty
    property p_ref_half3;
        $rose(ref_clock_out) && cfg.master && cfg.mult == 2'h3
            |-> ref_clock_out [*4] ##1 !ref_clock_out;
    endproperty
    property p_sync_en;
        $past(resetn, 2) |-> sync_out_en == $past(cfg.sync_gen);
    endproperty
    // Embedded sync is legal in YCrCb only.
    property p_fmt_err;
        $past(resetn, 2) |-> format_error == ($past(cfg.fmt) > 4'h9
            || ($past(cfg.embedded) && $past(cfg.fmt) != 4'h1
                && $past(cfg.fmt) != 4'h9));
    endproperty
    property p_err_blocks;
        format_error |-> !pixel_valid;
    endproperty
    property p_valid_pulse;
        pixel_valid |=> !pixel_valid;
    endproperty
    property p_rgb565;
        pixel_valid && cfg.fmt == tv_pix_pkg::FMT_565 |-> !pixel.ycc
            && pixel.c3 == 8'h00 && pixel.c0[2:0] == 3'h0
            && pixel.c1[1:0] == 2'h0 && pixel.c2[2:0] == 3'h0;
    endproperty
    property p_ycc16;
        pixel_valid && cfg.fmt == tv_pix_pkg::FMT_YCC16 |-> pixel.ycc;
    endproperty
    property p_limit;
        !clock_limit_error;
    endproperty
    property p_line_pulse;
        line_start |=> !line_start;
    endproperty

    a_slave_quiet: assert property (p_slave_quiet)
        else $error("ref clock in slave");
    a_ref_half2: assert property (p_ref_half2)
        else $error("ref half period at 2X");
    a_ref_half3: assert property (p_ref_half3)
        else $error("ref half period at 3X");
    a_sync_en: assert property (p_sync_en)
        else $error("sync enable wrong");
    a_fmt_err: assert property (p_fmt_err)
        else $error("format error wrong");
    a_err_blocks: assert property (p_err_blocks)
        else $error("pixel with bad format");
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("valid too long");
    a_rgb565: assert property (p_rgb565)
        else $error("5-6-5 fields wrong");
    a_ycc16: assert property (p_ycc16)
        else $error("YCrCb not flagged");
    a_limit: assert property (p_limit)
        else $error("clock limit flagged");
    a_line_pulse: assert property (p_line_pulse)
        else $error("line start too long");

    c_pixel: cover property (pixel_valid);
    c_line: cover property (line_start);
    c_ref3: cover property ($rose(ref_clock_out) && cfg.mult == 2'h3);
    c_err: cover property (format_error);
endmodule : tv_pix_checker

bind tv_pixel_input_port tv_pix_checker u_chk (.clk, .resetn, .cfg,
    .ref_clock_out, .sync_out_en, .pixel, .pixel_valid, .line_start,
    .format_error, .clock_limit_error);

// File: verilog/tv_pix_pkg.sv
// Constants, types and helpers for the pixel input port.
// Summary of operation
// - Buses 8/12/16 multiplexed, 16 non-multiplexed.
// - RGB 15/16/24 or YCrCb, any scan.
// - 8-bit: RGB16/15 two bytes, YCrCb Cb-Y-Cr-Y.
// - 8-bit RGB24 takes three bytes per pixel.
// - RGB24 over two 12- or 16-bit words.
// - Master: reference clock out, capture clock in.
// - Capture rate equals data; reference 1X/2X/3X.
// - Loop-back timing only adjusted by clock inversion.
// - Slave: no reference clock driven out.
// - 1X multiplexed capture uses both clock edges.
// - Requested pixel clock never above 100MHz.
// - Syncs may be generated inside the device.
// - Embedded sync allowed for codes 1, 9.
// - Hsync leading edge starts each line.
// - Active after offset times multiplex rate.
// - Codes 0, 3 decode 5-6-5, 5-5-5 words.
// - 16-bit YCrCb: Y high byte, C low.
// - Cb then Cr, paired with Cb's luma.
// - Non-multiplexed offset counts from hsync trailing.
// - Code 1 reference starts in Cb slot.
// - Status bits: 6 field, 5 vblank, 4 EAV.
// - Status bits 7 and 3..0 ignored.
// - Code 6 three words, 9 four, 0 and 3 one, others two.
package tv_pix_pkg;

    // --------
    // Timing
    // --------
    localparam int CLK_HZ        = 10_000_000;
    localparam int CLK_NS        = 1_000_000_000 / CLK_HZ;
    localparam int LIMIT_HZ      = 100_000_000;
    localparam int PIX_PERIOD_NS = 2400;
    localparam int PIX_CYCLES    = PIX_PERIOD_NS / CLK_NS;

    // --------
    // Codes and fields
    // --------
    localparam logic [3:0] FMT_565    = 4'h0;
    localparam logic [3:0] FMT_YCC16  = 4'h1;
    localparam logic [3:0] FMT_RGB2X  = 4'h2;
    localparam logic [3:0] FMT_555    = 4'h3;
    localparam logic [3:0] FMT_12C    = 4'h4;
    localparam logic [3:0] FMT_12I    = 4'h5;
    localparam logic [3:0] FMT_888X3  = 4'h6;
    localparam logic [3:0] FMT_565X2  = 4'h7;
    localparam logic [3:0] FMT_555X2  = 4'h8;
    localparam logic [3:0] FMT_YCC8   = 4'h9;
    localparam logic [1:0] MULT_1X    = 2'h1;
    localparam logic [1:0] MULT_3X    = 2'h3;
    localparam logic [15:0] TRS_WORD  = 16'h00ff;
    localparam logic [7:0] BYTE_ONES  = 8'hff;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam int ST_F = 6;
    localparam int ST_V = 5;
    localparam int ST_H = 4;
    localparam logic [13:0] GEN_HS_WIDTH = 14'h0010;
    localparam logic [10:0] GEN_VS_LINES = 11'h003;

    // --------
    // Types
    // --------
    typedef struct packed {
        logic        clk;
        logic        hs;
        logic        vs;
        logic [15:0] d;
    } link_s;

    typedef struct packed {
        logic        master;
        logic [1:0]  mult;
        logic        invert;
        logic [3:0]  fmt;
        logic        sync_gen;
        logic        embedded;
        logic [11:0] offset;
        logic [11:0] line_total;
        logic [10:0] frame_total;
    } cfg_s;

    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic       ycc;
    } pixel_s;

    // --------
    // Helpers
    // --------
    function automatic logic [1:0] mux_rate(input logic [3:0] f);
        if (f == FMT_888X3) return 2'h3;
        if (f == FMT_565 || f == FMT_555 || f == FMT_YCC16) return 2'h1;
        return 2'h2;
    endfunction : mux_rate

    function automatic logic [2:0] group_words(input logic [3:0] f);
        if (f == FMT_YCC8) return 3'h4;
        if (f == FMT_YCC16) return 3'h2;
        return {1'b0, mux_rate(f)};
    endfunction : group_words

    function automatic logic [4:0] ref_half(input logic [1:0] m);
        logic [1:0] k;
        k = (m == 2'h0) ? MULT_1X : m;
        return 5'(PIX_CYCLES / (2 * int'(k)));
    endfunction : ref_half

endpackage : tv_pix_pkg

// File: verilog/tv_pixel_input_port.sv
// Pixel input port: capture, demultiplex, sync handling.
`timescale 1ns/1ns
module tv_pixel_input_port (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Link from the graphics controller
    input  wire logic               capture_clock_in,
    input  wire logic               hsync_in,
    input  wire logic               vsync_in,
    input  wire logic [15:0]        pixel_word,
    // Configuration
    input  wire tv_pix_pkg::cfg_s   cfg,
    // Clock and sync towards the controller
    output logic                    ref_clock_out,
    output logic                    hsync_out,
    output logic                    vsync_out,
    output logic                    sync_out_en,
    // Pixels out
    output tv_pix_pkg::pixel_s      pixel,
    output logic                    pixel_valid,
    output logic                    line_start,
    output logic                    field,
    output logic                    vblank,
    // Status
    output logic                    format_error,
    output logic                    clock_limit_error
);

    typedef enum logic [3:0] {
        TRS_IDLE = 4'h1,
        TRS_Z1   = 4'h2,
        TRS_Z2   = 4'h4,
        TRS_STAT = 4'h8
    } trs_e;

    // --------
    // Synchronisers
    // --------
    tv_pix_pkg::link_s s1_q, s2_q;
    logic              clk_prev_q, hs_prev_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {capture_clock_in, hsync_in, vsync_in, pixel_word};
            s2_q <= s1_q;
        end
    end

    // Inversion is the only skew adjustment for a looped-back clock.
    logic clk_lvl;
    assign clk_lvl = s2_q.clk ^ cfg.invert;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_prev_q <= 1'b0;
            hs_prev_q  <= 1'b0;
        end else begin
            clk_prev_q <= clk_lvl;
            hs_prev_q  <= s2_q.hs;
        end
    end

    // --------
    // Capture events
    // --------
    logic       is_mux, both_edges, cap_evt, hs_lead, hs_trail;
    logic [1:0] rate;
    logic [2:0] gwords;
    logic       ycc_fmt, emb_ok;

    assign rate    = tv_pix_pkg::mux_rate(cfg.fmt);
    assign gwords  = tv_pix_pkg::group_words(cfg.fmt);
    assign is_mux  = (rate != 2'h1);
    assign both_edges = is_mux && (cfg.mult == tv_pix_pkg::MULT_1X
                                   || cfg.mult == 2'h0);
    // One word per capture edge, so the word rate follows the clock.
    assign cap_evt = (clk_lvl & ~clk_prev_q)
                   | (both_edges & ~clk_lvl & clk_prev_q);
    assign hs_lead  = s2_q.hs & ~hs_prev_q;
    assign hs_trail = ~s2_q.hs & hs_prev_q;
    assign ycc_fmt  = (cfg.fmt == tv_pix_pkg::FMT_YCC16)
                   || (cfg.fmt == tv_pix_pkg::FMT_YCC8);
    assign emb_ok   = cfg.embedded && ycc_fmt;

    // --------
    // Reference clock
    // --------
    logic [4:0] ref_cnt_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_cnt_q     <= '0;
            ref_clock_out <= 1'b0;
        end else if (!cfg.master) begin
            ref_cnt_q     <= '0;
            ref_clock_out <= 1'b0;
        end else if (ref_cnt_q >= tv_pix_pkg::ref_half(cfg.mult) - 5'h1) begin
            ref_cnt_q     <= '0;
            ref_clock_out <= ~ref_clock_out;
        end else begin
            ref_cnt_q <= ref_cnt_q + 5'h1;
        end
    end

    // The divider cannot pass the limit here, but the flag keeps a
    // faster system clock honest.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clock_limit_error <= 1'b0;
        end else begin
            clock_limit_error <= cfg.master && (tv_pix_pkg::CLK_HZ
                / (2 * int'(tv_pix_pkg::ref_half(cfg.mult)))
                > tv_pix_pkg::LIMIT_HZ);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            format_error <= 1'b0;
        end else begin
            format_error <= (cfg.fmt > tv_pix_pkg::FMT_YCC8)
                         || (cfg.embedded && !ycc_fmt);
        end
    end

    // --------
    // Sync generator
    // --------
    logic [13:0] gen_h_q;
    logic [10:0] gen_v_q;
    logic [13:0] line_words;
    logic        gen_start;

    assign line_words = 14'(cfg.line_total * rate);
    assign gen_start  = cfg.sync_gen && cap_evt && (gen_h_q == '0);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gen_h_q <= '0;
            gen_v_q <= '0;
        end else if (!cfg.sync_gen) begin
            gen_h_q <= '0;
            gen_v_q <= '0;
        end else if (cap_evt) begin
            if (gen_h_q >= line_words - 14'h1) begin
                gen_h_q <= '0;
                if (gen_v_q >= cfg.frame_total - 11'h1) gen_v_q <= '0;
                else gen_v_q <= gen_v_q + 11'h1;
            end else begin
                gen_h_q <= gen_h_q + 14'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hsync_out   <= 1'b0;
            vsync_out   <= 1'b0;
            sync_out_en <= 1'b0;
        end else begin
            hsync_out   <= cfg.sync_gen && gen_h_q
                        < 14'(tv_pix_pkg::GEN_HS_WIDTH * rate);
            vsync_out   <= cfg.sync_gen
                        && gen_v_q < tv_pix_pkg::GEN_VS_LINES;
            sync_out_en <= cfg.sync_gen;
        end
    end

    // --------
    // Embedded timing reference
    // --------
    trs_e       trs_q;
    logic [2:0] ph_q;
    logic       ref_done, sav_hit, eav_hit, trs_open;
    logic [7:0] cur_b, stat;

    assign cur_b = s2_q.d[7:0];
    assign stat  = (cfg.fmt == tv_pix_pkg::FMT_YCC16) ? s2_q.d[15:8]
                                                       : cur_b;
    // A reference opens in a Cb slot for code 1, in a Cb or Cr slot for code 9.
    assign trs_open = (cfg.fmt == tv_pix_pkg::FMT_YCC16)
                    ? (s2_q.d == tv_pix_pkg::TRS_WORD && ph_q == 3'h0)
                    : (cur_b == tv_pix_pkg::BYTE_ONES && !ph_q[0]);
    // Only F, V and H are looked at.
    assign ref_done = emb_ok && cap_evt && (trs_q == TRS_STAT)
                   && (cfg.fmt == tv_pix_pkg::FMT_YCC8
                       || cur_b == tv_pix_pkg::BYTE_ZERO);
    assign eav_hit  = ref_done && stat[tv_pix_pkg::ST_H];
    assign sav_hit  = ref_done && !stat[tv_pix_pkg::ST_H];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trs_q <= TRS_IDLE;
        end else if (!emb_ok) begin
            trs_q <= TRS_IDLE;
        end else if (cap_evt) begin
            unique case (trs_q)
                TRS_IDLE: if (trs_open)
                    trs_q <= (cfg.fmt == tv_pix_pkg::FMT_YCC16)
                             ? TRS_STAT : TRS_Z1;
                TRS_Z1: trs_q <= (cur_b == tv_pix_pkg::BYTE_ZERO)
                                 ? TRS_Z2 : TRS_IDLE;
                TRS_Z2: trs_q <= (cur_b == tv_pix_pkg::BYTE_ZERO)
                                 ? TRS_STAT : TRS_IDLE;
                TRS_STAT: trs_q <= TRS_IDLE;
                default: trs_q <= TRS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            field  <= 1'b0;
            vblank <= 1'b0;
        end else if (ref_done) begin
            field  <= stat[tv_pix_pkg::ST_F];
            vblank <= stat[tv_pix_pkg::ST_V];
        end else if (!emb_ok) begin
            field  <= 1'b0;
            vblank <= cfg.sync_gen ? vsync_out : s2_q.vs;
        end
    end

    // --------
    // Line start and active window
    // --------
    logic        start_line, start_ref, active_q, active_now, word_in;
    logic [13:0] since_q, delay;

    assign start_line = emb_ok ? eav_hit
                      : (cfg.sync_gen ? gen_start : hs_lead);
    assign start_ref  = is_mux ? start_line
                      : (cfg.sync_gen ? gen_start
                         : (emb_ok ? 1'b0 : hs_trail));
    assign delay      = 14'(cfg.offset * rate);
    assign active_now = active_q || (!emb_ok && since_q == delay);
    assign word_in    = cap_evt && active_now && (trs_q == TRS_IDLE)
                     && !(emb_ok && (!active_q || trs_open));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_q  <= '0;
            active_q <= 1'b0;
        end else if (emb_ok) begin
            since_q <= '0;
            if (sav_hit) active_q <= 1'b1;
            else if (eav_hit) active_q <= 1'b0;
        end else if (start_ref) begin
            since_q  <= '0;
            active_q <= 1'b0;
        end else if (cap_evt && !active_q) begin
            since_q <= since_q + 14'h1;
            if (since_q == delay) active_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) line_start <= 1'b0;
        else line_start <= start_line;
    end

    // --------
    // Word grouping
    // --------
    logic [15:0] hold_q [0:2];
    logic        last_word;

    assign last_word = (ph_q == gwords - 3'h1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ph_q <= '0;
            hold_q <= '{default: '0};
        end else if (start_ref || sav_hit || (emb_ok && eav_hit)) begin
            ph_q <= '0;
        end else if (word_in) begin
            if (last_word) ph_q <= '0;
            else begin
                hold_q[ph_q[1:0]] <= s2_q.d;
                ph_q <= ph_q + 3'h1;
            end
        end
    end

    // --------
    // Pixel decode
    // --------
    tv_pix_pkg::pixel_s px_d;
    logic [15:0] d, h0, h1, h2;

    assign d  = s2_q.d;
    assign h0 = hold_q[0];
    assign h1 = hold_q[1];
    assign h2 = hold_q[2];

    always_comb begin
        px_d = '0;
        unique case (cfg.fmt)
            tv_pix_pkg::FMT_565: begin
                px_d.c0 = {d[15:11], 3'h0};
                px_d.c1 = {d[10:5], 2'h0};
                px_d.c2 = {d[4:0], 3'h0};
            end
            tv_pix_pkg::FMT_555: begin
                px_d.c0 = {d[14:10], 3'h0};
                px_d.c1 = {d[9:5], 3'h0};
                px_d.c2 = {d[4:0], 3'h0};
            end
            tv_pix_pkg::FMT_YCC16: begin
                px_d.c0  = h0[15:8];
                px_d.c1  = h0[7:0];
                px_d.c2  = d[7:0];
                px_d.c3  = d[15:8];
                px_d.ycc = 1'b1;
            end
            tv_pix_pkg::FMT_YCC8: begin
                px_d.c0  = h1[7:0];
                px_d.c1  = h0[7:0];
                px_d.c2  = h2[7:0];
                px_d.c3  = d[7:0];
                px_d.ycc = 1'b1;
            end
            tv_pix_pkg::FMT_565X2: begin
                px_d.c0 = {d[7:3], 3'h0};
                px_d.c1 = {d[2:0], h0[7:5], 2'h0};
                px_d.c2 = {h0[4:0], 3'h0};
            end
            tv_pix_pkg::FMT_555X2: begin
                px_d.c0 = {d[6:2], 3'h0};
                px_d.c1 = {d[1:0], h0[7:5], 3'h0};
                px_d.c2 = {h0[4:0], 3'h0};
            end
            tv_pix_pkg::FMT_888X3: begin
                px_d.c0 = d[7:0];
                px_d.c1 = h1[7:0];
                px_d.c2 = h0[7:0];
            end
            tv_pix_pkg::FMT_12C: begin
                px_d.c0 = d[11:4];
                px_d.c1 = {d[3:0], h0[11:8]};
                px_d.c2 = h0[7:0];
            end
            tv_pix_pkg::FMT_12I: begin
                px_d.c0 = {d[11:7], d[3:1]};
                px_d.c1 = {d[6:4], h0[11:9], d[0], h0[3]};
                px_d.c2 = {h0[8:4], h0[2:0]};
            end
            tv_pix_pkg::FMT_RGB2X: begin
                px_d.c0 = d[7:0];
                px_d.c1 = h0[15:8];
                px_d.c2 = h0[7:0];
            end
            default: px_d = '0;
        endcase
    end

    // Interlace needs nothing extra: each field is a run of lines.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pixel       <= '0;
            pixel_valid <= 1'b0;
        end else begin
            pixel_valid <= word_in && last_word && !format_error;
            if (word_in && last_word) pixel <= px_d;
        end
    end

endmodule : tv_pixel_input_port
